// [verilog/ecs_consts.svh]
// numeric constants of the error code status display block
`ifndef ECS_CONSTS_SVH
`define ECS_CONSTS_SVH

// number of error sources, one pending bit each
`define ECS_N_SRC           29
`define ECS_IDX_W           5
`define ECS_TASK_TIME_W     16
`define ECS_LOAD_W          7

// two-digit error codes, listed in ascending order (index order of the pending vector)
`define ECS_CODE_OS_ROM     8'h11
`define ECS_CODE_RAM        8'h12
`define ECS_CODE_FS_ROM     8'h17
`define ECS_CODE_MAC        8'h18
`define ECS_CODE_PMIC       8'h1A
`define ECS_CODE_FLASH      8'h1F
`define ECS_CODE_ILL_INSN   8'h20
`define ECS_CODE_RETAIN     8'h21
`define ECS_CODE_UNRES      8'h23
`define ECS_CODE_TASK_WDT   8'h24
`define ECS_CODE_LOAD_WDT   8'h25
`define ECS_CODE_TASK_CFG   8'h26
`define ECS_CODE_IDIV_ZERO  8'h27
`define ECS_CODE_FDIV_ZERO  8'h28
`define ECS_CODE_ACC_VIOL   8'h29
`define ECS_CODE_OVERFLOW   8'h2A
`define ECS_CODE_FPU_OVER   8'h2B
`define ECS_CODE_FPU_UNDER  8'h2C
`define ECS_CODE_FPU_INEXT  8'h2D
`define ECS_CODE_FPU_INVAL  8'h2E
`define ECS_CODE_FPU_OTHER  8'h2F
`define ECS_CODE_IO_CFG     8'h70
`define ECS_CODE_BATTERY    8'h71
`define ECS_CODE_SPEC_MOD   8'h72
`define ECS_CODE_COMM_CFG   8'h74
`define ECS_CODE_FLASH_WR   8'h77
`define ECS_CODE_IP_CSUM    8'h78
`define ECS_CODE_RTC_INIT   8'h79
`define ECS_CODE_HW_WDT     8'h88
`define ECS_CODE_NONE       8'h00

// error level bands
`define ECS_SER_LO          8'h11
`define ECS_SER_HI          8'h1F
`define ECS_EXC_LO          8'h20
`define ECS_EXC_HI          8'h59
`define ECS_WARN_LO         8'h70
`define ECS_WARN_HI         8'h79

// sources only checked during the power-on phase
`define ECS_POR_ONLY_MASK   29'h0C0000BF

// processor load thresholds in percent
`define ECS_LOAD_THR_OLD    7'h50
`define ECS_LOAD_THR_NEW    7'h64

`endif

// [verilog/ecs_pkg.sv]
// types shared by the error code status display block
`include "ecs_consts.svh"
package ecs_pkg;

    // power-on check phase, then normal operation
    typedef enum logic {
        ECS_POR_CHECK,
        ECS_RUN
    } ecs_state_type;

    // reset command kinds from the host tool
    typedef enum logic [1:0] {
        ECS_RST_COLD,
        ECS_RST_WARM,
        ECS_RST_ORIGIN,
        ECS_RST_NONE
    } ecs_rst_kind_type;

    // one bit per source; bit 0 is the lowest code, the first field the highest
    typedef struct packed {
        logic hw_wdt;
        logic rtc_init;
        logic ip_csum;
        logic flash_wr;
        logic comm_cfg;
        logic spec_mod;
        logic battery;
        logic io_cfg;
        logic fpu_other;
        logic fpu_inval;
        logic fpu_inexact;
        logic fpu_under;
        logic fpu_over;
        logic overflow;
        logic acc_viol;
        logic fdiv_zero;
        logic idiv_zero;
        logic task_cfg;
        logic load_wdt;
        logic task_wdt;
        logic unresolved;
        logic retain_bad;
        logic illegal_insn;
        logic flash_fail;
        logic pmic_fail;
        logic mac_bad;
        logic fs_csum;
        logic ram_fail;
        logic os_csum;
    } ecs_err_vec_type;

    typedef struct packed {
        logic                        valid;
        logic [`ECS_TASK_TIME_W-1:0] cycle_time;
        logic [`ECS_TASK_TIME_W-1:0] wdt_time;
    } ecs_task_chk_type;

    typedef struct packed {
        logic valid;
        logic is_float;
        logic divisor_zero;
    } ecs_div_chk_type;

    // two hexadecimal digits of the status display
    typedef struct packed {
        logic [3:0] hi;
        logic [3:0] lo;
    } ecs_disp_type;

    typedef struct packed {
        logic on;
        logic flash;
    } ecs_led_type;

    typedef struct packed {
        ecs_state_type   state;
        ecs_err_vec_type pend;
        logic            btn_s1;
        logic            btn_s2;
        logic            btn_d;
        ecs_disp_type    disp;
        ecs_led_type     led;
        logic            sys_run;
        logic            app_run;
    } ecs_state_reg_type;

endpackage

// [verilog/ecs_prio_select.sv]
// lowest-index selector over the pending error vector
`timescale 1ns/10ps
module ecs_prio_select #(
    parameter int N     = 29,
    parameter int IDX_W = 5
) (
    input  wire logic [N-1:0]     i_pend,
    output logic                  o_any,
    output logic [IDX_W-1:0]      o_idx
);

    // scan downward so the lowest set bit wins; index order equals code order
    always_comb begin
        o_any = 1'b0;
        o_idx = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (i_pend[i]) begin
                o_any = 1'b1;
                o_idx = IDX_W'(i);
            end
        end
    end

endmodule

// [verilog/ecs_status_display.sv]
// error collector, level classifier and two-digit status display driver
`timescale 1ns/10ps
`include "ecs_consts.svh"

// Summary of operation
// - with several errors pending, the smallest code is displayed
// - 88 and 11..1F are serious, latched until power cycle, stop everything
// - 20..59 are exceptions, cleared only by a cold, warm or origin reset
// - 70..79 are warnings and stop neither system nor application
// - the operator clear button clears a displayed warning code
// - hardware watchdog expiry raises 88 and stops system and application
// - power-on checksum mismatch raises 11 for the OS and 17 for files
// - failed power-on RAM read/write check raises 12
// - missing or invalid network address at power-on raises 18
// - failed power management initialisation at power-on raises 1A
// - failed flash access at power-on raises 1F
// - codes 20..2F keep the system running and stop the application
// - retained memory checksum error at power-on raises 21
// - task cycle time above its watchdog time raises 24
// - processor load at 80 or 100 percent by firmware raises 25
// - zero divisor raises 27 for integer and 28 for float division
// - float faults raise 2B, 2C, 2D, 2E and 2F
// - processor overflow raises 2A, access violation raises 29
// - while the system is stopped, host tool communication is refused
// - low battery flashes the error indicator, unless a serious or exception code holds it steadily on, and shows 71
// - codes stay latched, except 71 which follows the battery
// - display shows 00 with nothing pending, else the selected code
module ecs_status_display (
    input  wire logic                      i_core_clk,
    input  wire logic                      i_rstn,
    input  wire logic                      i_ce,
    input  wire ecs_pkg::ecs_err_vec_type  i_detect,
    input  wire logic                      i_por_done,
    input  wire ecs_pkg::ecs_task_chk_type i_task_chk,
    input  wire logic [`ECS_LOAD_W-1:0]    i_cpu_load_pct,
    input  wire logic                      i_fw_newer,
    input  wire ecs_pkg::ecs_div_chk_type  i_div_chk,
    input  wire logic                      i_reset_cmd,
    input  wire ecs_pkg::ecs_rst_kind_type i_reset_kind,
    input  wire logic                      i_error_clear_button,
    output ecs_pkg::ecs_disp_type          o_disp,
    output ecs_pkg::ecs_led_type           o_err_led,
    output logic                           o_sys_run,
    output logic                           o_app_run,
    output logic                           o_host_comm_en
);

    localparam int N_SRC = `ECS_N_SRC;
    localparam int IDX_W = `ECS_IDX_W;

    // code of each pending bit, ascending
    localparam logic [7:0] CODE_TAB [0:N_SRC-1] = '{
        `ECS_CODE_OS_ROM,    `ECS_CODE_RAM,       `ECS_CODE_FS_ROM,   `ECS_CODE_MAC,
        `ECS_CODE_PMIC,      `ECS_CODE_FLASH,     `ECS_CODE_ILL_INSN, `ECS_CODE_RETAIN,
        `ECS_CODE_UNRES,     `ECS_CODE_TASK_WDT,  `ECS_CODE_LOAD_WDT, `ECS_CODE_TASK_CFG,
        `ECS_CODE_IDIV_ZERO, `ECS_CODE_FDIV_ZERO, `ECS_CODE_ACC_VIOL, `ECS_CODE_OVERFLOW,
        `ECS_CODE_FPU_OVER,  `ECS_CODE_FPU_UNDER, `ECS_CODE_FPU_INEXT, `ECS_CODE_FPU_INVAL,
        `ECS_CODE_FPU_OTHER, `ECS_CODE_IO_CFG,    `ECS_CODE_BATTERY,  `ECS_CODE_SPEC_MOD,
        `ECS_CODE_COMM_CFG,  `ECS_CODE_FLASH_WR,  `ECS_CODE_IP_CSUM,  `ECS_CODE_RTC_INIT,
        `ECS_CODE_HW_WDT
    };

    function automatic logic [7:0] code_of(input logic [IDX_W-1:0] idx);
        code_of = CODE_TAB[idx];
    endfunction

    function automatic logic is_serious(input logic [7:0] code);
        is_serious = (code == `ECS_CODE_HW_WDT) ||
                     (code >= `ECS_SER_LO && code <= `ECS_SER_HI);
    endfunction

    function automatic logic is_exc(input logic [7:0] code);
        is_exc = (code >= `ECS_EXC_LO) && (code <= `ECS_EXC_HI);
    endfunction

    function automatic logic is_warn(input logic [7:0] code);
        is_warn = (code >= `ECS_WARN_LO) && (code <= `ECS_WARN_HI);
    endfunction

    ecs_pkg::ecs_state_reg_type st_reg;
    ecs_pkg::ecs_state_reg_type st_next;
    logic [N_SRC-1:0]           ser_mask;
    logic [N_SRC-1:0]           exc_mask;
    logic [N_SRC-1:0]           warn_mask;
    logic                       sel_any;
    logic [IDX_W-1:0]           sel_idx;
    logic [7:0]                 sel_code;
    logic [`ECS_LOAD_W-1:0]     load_thr;

    // level masks derived from the code table, constant after elaboration
    always_comb begin
        for (int i = 0; i < N_SRC; i++) begin
            ser_mask[i]  = is_serious(CODE_TAB[i]);
            exc_mask[i]  = is_exc(CODE_TAB[i]);
            warn_mask[i] = is_warn(CODE_TAB[i]);
        end
    end

    // single-cycle selection of the lowest pending code
    ecs_prio_select #(
        .N     (N_SRC),
        .IDX_W (IDX_W)
    ) u_prio (
        .i_pend (st_reg.pend),
        .o_any  (sel_any),
        .o_idx  (sel_idx)
    );

    assign sel_code = sel_any ? code_of(sel_idx) : `ECS_CODE_NONE;
    assign load_thr = i_fw_newer ? `ECS_LOAD_THR_NEW : `ECS_LOAD_THR_OLD;

    // next-state logic: sets, clears, display and run enables
    always_comb begin
        ecs_pkg::ecs_err_vec_type det;
        logic [N_SRC-1:0]         set_v;
        logic [N_SRC-1:0]         clr_v;
        logic                     press;
        det     = i_detect;
        st_next = st_reg;
        clr_v   = '0;
        set_v   = '0;
        press   = 1'b0;
        // internal comparators feed the same sources as the direct flags
        if (i_task_chk.valid && (i_task_chk.cycle_time > i_task_chk.wdt_time)) begin
            det.task_wdt = 1'b1;
        end
        if (i_cpu_load_pct >= load_thr) begin
            det.load_wdt = 1'b1;
        end
        if (i_div_chk.valid && i_div_chk.divisor_zero) begin
            if (i_div_chk.is_float) begin
                det.fdiv_zero = 1'b1;
            end else begin
                det.idiv_zero = 1'b1;
            end
        end
        // power-on checks count only before the check phase is closed
        set_v = N_SRC'(det);
        if (st_reg.state != ecs_pkg::ECS_POR_CHECK) begin
            set_v = set_v & ~`ECS_POR_ONLY_MASK;
        end
        // button: two-stage synchroniser, then rising-edge detect on the second stage
        st_next.btn_s1 = i_error_clear_button;
        st_next.btn_s2 = st_reg.btn_s1;
        st_next.btn_d  = st_reg.btn_s2;
        press          = st_reg.btn_s2 && !st_reg.btn_d;
        if (press && sel_any && is_warn(sel_code)) begin
            clr_v[sel_idx] = 1'b1;
        end
        // only a real reset command kind clears exceptions; serious codes never clear
        if (i_reset_cmd && (i_reset_kind != ecs_pkg::ECS_RST_NONE)) begin
            clr_v = clr_v | exc_mask;
        end
        // set wins over clear so an event in the clearing cycle is kept
        st_next.pend = ecs_pkg::ecs_err_vec_type'(
            (N_SRC'(st_reg.pend) & ~clr_v) | set_v);
        // the battery bit is a level and clears itself once replaced
        st_next.pend.battery = det.battery;
        // display and outputs lag the pending vector by one cycle
        st_next.disp = ecs_pkg::ecs_disp_type'(sel_code);
        st_next.led.on    = |(N_SRC'(st_reg.pend) & (ser_mask | exc_mask));
        st_next.led.flash = !st_next.led.on &&
                            |(N_SRC'(st_reg.pend) & warn_mask);
        // warnings are absent here on purpose: they never stop anything
        st_next.sys_run = (st_reg.state == ecs_pkg::ECS_RUN) &&
                          !(|(N_SRC'(st_reg.pend) & ser_mask));
        st_next.app_run = st_next.sys_run &&
                          !(|(N_SRC'(st_reg.pend) & exc_mask));
        case (st_reg.state)
            ecs_pkg::ECS_POR_CHECK: begin
                if (i_por_done) begin
                    st_next.state = ecs_pkg::ECS_RUN;
                end
            end
            ecs_pkg::ECS_RUN: begin
                st_next.state = ecs_pkg::ECS_RUN;
            end
            default: begin
                st_next.state = ecs_pkg::ECS_POR_CHECK;
            end
        endcase
    end

    // all state frozen while the clock enable is low; reset is power-on only
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= '0;
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    assign o_disp         = st_reg.disp;
    assign o_err_led      = st_reg.led;
    assign o_sys_run      = st_reg.sys_run;
    assign o_app_run      = st_reg.app_run;
    // a stopped system program cannot talk to the host tool
    assign o_host_comm_en = st_reg.sys_run;

    a_lowest_shown: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        i_ce |=> (o_disp == ecs_pkg::ecs_disp_type'($past(sel_code))))
        else $error("display does not show lowest pending code");

    a_idle_shows_zero: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && !(|st_reg.pend)) |=> (o_disp == ecs_pkg::ecs_disp_type'(8'h00)))
        else $error("display not 00 with nothing pending");

    a_serious_stops: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && |(N_SRC'(st_reg.pend) & ser_mask)) |=> (!o_sys_run && !o_app_run))
        else $error("serious error did not stop execution");

    a_serious_kept: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        i_ce |=> ((N_SRC'(st_reg.pend) & $past(N_SRC'(st_reg.pend) & ser_mask))
                  == $past(N_SRC'(st_reg.pend) & ser_mask)))
        else $error("serious code was cleared");

    a_exc_only_reset: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && !i_reset_cmd) |=>
        ((N_SRC'(st_reg.pend) & $past(N_SRC'(st_reg.pend) & exc_mask))
         == $past(N_SRC'(st_reg.pend) & exc_mask)))
        else $error("exception code cleared without reset command");

    a_warn_no_stop: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && st_reg.state == ecs_pkg::ECS_RUN &&
         !(|(N_SRC'(st_reg.pend) & (ser_mask | exc_mask)))) |=> (o_sys_run && o_app_run))
        else $error("warning stopped execution");

    a_wdt_stops: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && i_detect.hw_wdt) ##1 i_ce |=> (!o_sys_run && !o_app_run && o_err_led.on))
        else $error("watchdog expiry did not stop execution");

    a_exc_app_stop: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && st_reg.state == ecs_pkg::ECS_RUN && |(N_SRC'(st_reg.pend) & exc_mask) &&
         !(|(N_SRC'(st_reg.pend) & ser_mask))) |=> (o_sys_run && !o_app_run))
        else $error("exception did not stop only the application");

    a_host_refused: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        !o_sys_run |-> !o_host_comm_en)
        else $error("host communication allowed while stopped");

    a_battery_follows: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && !i_detect.battery) |=> !st_reg.pend.battery)
        else $error("battery code did not clear after replacement");

    a_load_raises: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && i_cpu_load_pct >= load_thr) |=> st_reg.pend.load_wdt)
        else $error("processor load threshold did not raise 25");

    a_div_zero: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && i_div_chk.valid && i_div_chk.divisor_zero) |=>
        ($past(i_div_chk.is_float) ? st_reg.pend.fdiv_zero : st_reg.pend.idiv_zero))
        else $error("zero divisor did not raise its code");

    a_os_sum_raise: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && st_reg.state == ecs_pkg::ECS_POR_CHECK && i_detect.os_csum) |=>
        st_reg.pend.os_csum)
        else $error("power-on image checksum failure did not raise 11");

    a_por_window: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && st_reg.state == ecs_pkg::ECS_RUN && !st_reg.pend.os_csum) |=>
        !st_reg.pend.os_csum)
        else $error("power-on check accepted after check phase");

    a_ram_check_raise: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && st_reg.state == ecs_pkg::ECS_POR_CHECK && i_detect.ram_fail) |=>
        st_reg.pend.ram_fail)
        else $error("power-on memory check failure did not raise 12");

    a_retain_raise: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && st_reg.state == ecs_pkg::ECS_POR_CHECK && i_detect.retain_bad) |=>
        st_reg.pend.retain_bad)
        else $error("retained data checksum failure did not raise 21");

    a_illegal_raise: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && i_detect.illegal_insn) |=> st_reg.pend.illegal_insn)
        else $error("illegal instruction did not raise 20");

    a_task_raise: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && i_task_chk.valid && (i_task_chk.cycle_time > i_task_chk.wdt_time)) |=>
        st_reg.pend.task_wdt)
        else $error("task cycle overrun did not raise 24");

    a_warn_clear: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && st_reg.btn_s2 && !st_reg.btn_d && sel_code == `ECS_CODE_IO_CFG &&
         !i_detect.io_cfg) |=> !st_reg.pend.io_cfg)
        else $error("button press did not clear the shown warning");

    a_battery_blink: assert property (
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && i_detect.battery) ##1
        (i_ce && !(|(N_SRC'(st_reg.pend) & (ser_mask | exc_mask)))) |=> o_err_led.flash)
        else $error("battery low did not flash the error indicator");

endmodule

// [verification/ecs_panel_model.sv]
// operator panel model: two-digit display reader and clear button
`timescale 1ns/10ps
module ecs_panel_model (
    input  wire logic                  i_core_clk,
    input  wire ecs_pkg::ecs_disp_type i_disp,
    input  wire ecs_pkg::ecs_led_type  i_err_led,
    input  wire logic                  i_press,
    output logic                       o_button,
    output logic [7:0]                 o_shown,
    output logic                       o_blinking
);
    // the panel reads the two digits as one code; blinking is the panel's job
    assign o_shown    = {i_disp.hi, i_disp.lo};
    assign o_blinking = i_err_led.flash;

    // the contact closes off the clock grid and stays shut for a few cycles,
    // so the design has to synchronise and edge-detect it
    initial begin
        o_button = 1'b0;
    end
    always @(posedge i_press) begin
        #17;
        o_button = 1'b1;
        repeat (6) @(posedge i_core_clk);
        #13;
        o_button = 1'b0;
    end
endmodule

// [verification/tb.sv]
// self-checking bench of the error code status display
`timescale 1ns/10ps
`include "ecs_consts.svh"
module tb;
    logic                      clk;
    logic                      rstn;
    logic                      ce;
    ecs_pkg::ecs_err_vec_type  det;
    logic                      por_done;
    ecs_pkg::ecs_task_chk_type task_chk;
    logic [6:0]                load;
    logic                      fw_newer;
    ecs_pkg::ecs_div_chk_type  div_chk;
    logic                      rst_cmd;
    ecs_pkg::ecs_rst_kind_type rst_kind;
    logic                      press;
    logic                      button;
    ecs_pkg::ecs_disp_type     disp;
    ecs_pkg::ecs_led_type      led;
    logic                      sys_run;
    logic                      app_run;
    logic                      comm_en;
    logic [7:0]                shown;
    logic                      blinking;
    int                        fails;
    int                        checks;
    int                        cycles;
    // codes in source order, bit 0 first
    localparam logic [7:0] CODES [29] = '{8'h11, 8'h12, 8'h17, 8'h18, 8'h1A, 8'h1F,
        8'h20, 8'h21, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B,
        8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h70, 8'h71, 8'h72, 8'h74, 8'h77, 8'h78, 8'h79,
        8'h88};
    localparam logic [28:0] POR_ONLY = 29'h0C0000BF;

    ecs_status_display uut (.i_core_clk(clk), .i_rstn(rstn), .i_ce(ce), .i_detect(det),
        .i_por_done(por_done), .i_task_chk(task_chk), .i_cpu_load_pct(load),
        .i_fw_newer(fw_newer), .i_div_chk(div_chk), .i_reset_cmd(rst_cmd),
        .i_reset_kind(rst_kind), .i_error_clear_button(button), .o_disp(disp),
        .o_err_led(led), .o_sys_run(sys_run), .o_app_run(app_run), .o_host_comm_en(comm_en));
    ecs_panel_model panel (.i_core_clk(clk), .i_disp(disp), .i_err_led(led), .i_press(press),
        .o_button(button), .o_shown(shown), .o_blinking(blinking));

    initial begin
        clk = 1'b0;
    end
    always #25 clk = ~clk;

    // hang guard: the whole run needs about 1800 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk_code(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask

    // land after the edge so registered outputs have settled
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic expect_st(input logic [7:0] code, input logic sys, input logic app);
        chk_code("display", code, shown);
        chk_bit("system run", sys, sys_run);
        chk_bit("application run", app, app_run);
        chk_bit("host link", sys, comm_en);
    endtask

    // 0 serious, 1 exception, 2 warning
    function automatic int level(input logic [7:0] c);
        if (c == 8'h88 || (c >= 8'h11 && c <= 8'h1F)) return 0;
        if (c >= 8'h20 && c <= 8'h59) return 1;
        return 2;
    endfunction

    task automatic power_up();
        @(posedge clk);
        rstn <= 1'b0;
        det <= '0;
        por_done <= 1'b0;
        tick(20);
        @(posedge clk);
        rstn <= 1'b1;
        tick(2);
        expect_st(8'h00, 1'b0, 1'b0);
    endtask

    task automatic pulse_vec(input logic [28:0] v);
        @(posedge clk);
        det <= ecs_pkg::ecs_err_vec_type'(v);
        @(posedge clk);
        det <= '0;
        tick(3);
    endtask

    task automatic enter_run();
        @(posedge clk);
        por_done <= 1'b1;
        @(posedge clk);
        por_done <= 1'b0;
        tick(3);
    endtask

    task automatic press_btn();
        @(posedge clk);
        press <= 1'b1;
        @(posedge clk);
        press <= 1'b0;
        tick(14);
    endtask

    task automatic host_reset(input int k);
        @(posedge clk);
        rst_cmd <= 1'b1;
        rst_kind <= ecs_pkg::ecs_rst_kind_type'(k);
        @(posedge clk);
        rst_cmd <= 1'b0;
        rst_kind <= ecs_pkg::ecs_rst_kind_type'(3);
        tick(3);
    endtask

    // every source but the battery (index 22) alone: code, level, and which clears work on it
    task automatic sc_each_source();
        int lv;
        for (int i = 0; i < 29; i++) begin
            lv = level(CODES[i]);
            if (i == 22) continue;
            power_up();
            if (POR_ONLY[i]) pulse_vec(29'h1 << i);
            enter_run();
            if (!POR_ONLY[i]) pulse_vec(29'h1 << i);
            expect_st(CODES[i], lv != 0, lv == 2);
            chk_bit("lamp on", lv != 2, led.on);
            press_btn();
            expect_st(lv == 2 ? 8'h00 : CODES[i], lv != 0, lv == 2);
            host_reset(i % 3);
            expect_st(lv == 0 ? CODES[i] : 8'h00, lv != 0, lv != 0);
        end
    endtask

    task automatic sc_priority();
        power_up();
        pulse_vec(29'h0000002A);
        enter_run();
        expect_st(8'h12, 1'b0, 1'b0);
    endtask

    task automatic sc_mixed();
        power_up();
        enter_run();
        pulse_vec(29'h00000001);
        expect_st(8'h00, 1'b1, 1'b1);
        pulse_vec(29'h00200040);
        expect_st(8'h20, 1'b1, 1'b0);
        press_btn();
        expect_st(8'h20, 1'b1, 1'b0);
        host_reset(3);
        expect_st(8'h20, 1'b1, 1'b0);
        host_reset(0);
        expect_st(8'h70, 1'b1, 1'b1);
        chk_bit("lamp blink", 1'b1, blinking);
        press_btn();
        expect_st(8'h00, 1'b1, 1'b1);
    endtask

    task automatic sc_checks();
        power_up();
        enter_run();
        @(posedge clk);
        ce <= 1'b0;
        pulse_vec(29'h00000040);
        @(posedge clk);
        ce <= 1'b1;
        tick(3);
        expect_st(8'h00, 1'b1, 1'b1);
        // watchdog compare is strictly greater
        @(posedge clk);
        task_chk <= '{1'b1, 16'h0100, 16'h0100};
        @(posedge clk);
        task_chk <= '{1'b1, 16'h0101, 16'h0100};
        @(posedge clk);
        task_chk <= '0;
        tick(3);
        expect_st(8'h24, 1'b1, 1'b0);
        host_reset(1);
        // load threshold per firmware generation, one below and at it
        for (int f = 0; f < 2; f++) begin
            @(posedge clk);
            fw_newer <= f[0];
            load <= f ? 7'h63 : 7'h4F;
            tick(4);
            expect_st(8'h00, 1'b1, 1'b1);
            @(posedge clk);
            load <= f ? 7'h64 : 7'h50;
            @(posedge clk);
            load <= 7'h00;
            tick(3);
            expect_st(8'h25, 1'b1, 1'b0);
            host_reset(2);
        end
        for (int fl = 0; fl < 2; fl++) begin
            @(posedge clk);
            div_chk <= '{1'b1, fl[0], 1'b1};
            @(posedge clk);
            div_chk <= '0;
            tick(3);
            expect_st(fl ? 8'h28 : 8'h27, 1'b1, 1'b0);
            host_reset(0);
        end
    endtask

    task automatic sc_battery();
        power_up();
        enter_run();
        @(posedge clk);
        det.battery <= 1'b1;
        tick(4);
        expect_st(8'h71, 1'b1, 1'b1);
        chk_bit("lamp blink", 1'b1, blinking);
        chk_bit("lamp on", 1'b0, led.on);
        @(posedge clk);
        det.battery <= 1'b0;
        tick(4);
        expect_st(8'h00, 1'b1, 1'b1);
        chk_bit("lamp blink", 1'b0, blinking);
    endtask

    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        det = '0;
        por_done = 1'b0;
        task_chk = '0;
        load = 7'h00;
        fw_newer = 1'b0;
        div_chk = '0;
        rst_cmd = 1'b0;
        rst_kind = ecs_pkg::ecs_rst_kind_type'(3);
        press = 1'b0;
        fails = 0;
        checks = 0;
        cycles = 0;
        sc_each_source();
        sc_priority();
        sc_mixed();
        sc_checks();
        sc_battery();
        give_verdict();
    end
endmodule
